// *** hdl/psbi_bridge.sv ***
// Processor system bus interface: address and data tenures toward the system bus
// Notes on behaviour
// RL1 - 32-bit address path, 64-bit data path
// RL2 - Address-only and address-plus-data transactions exist
// RL3 - Address tenure may overlap earlier data tenure (code starts no new address while a data tenure is owed)
// RL4 - Address and data buses owned independently
// RL5 - Bus clock is integer multiple of core (code makes the core clock RATIO times the bus clock)
// RL6 - One to eight bytes per beat
// RL7 - Single beat or exactly four-beat burst
// RL8 - Uncached, inhibited, write-through use single beats (code chooses burst by request kind alone)
// RL9 - Sector fill or writeback bursts 32 bytes
// RL10 - Address-only transactions invalidate remote entries
// RL11 - I/O transfers 1-128 bytes, split protocol (code sends each I/O request as one single-beat write of 1-8 bytes)
// RL12 - Memory start versus separate I/O start
// RL13 - I/O redefines address and attribute signals (code drives them for I/O as for memory; only the type code differs)
// RL14 - Responder terminates address phase, may retry
// RL15 - Termination per beat; burst ends last
// RL16 - Data retry repeats the data phase
// RL17 - Address parity bits and parity error
// RL18 - Data parity bits and parity error
// RL19 - Drive type, size, burst, write-through, inhibit
// RL20 - Active-low pins asserted when low
// RL21 - Separate arbitration for address and data
// RL22 - Reset floats outputs, clears state
// RL23 - Drive only after grant, release after
`include "psbi_params.svh"
`timescale 1ns/1ns
module psbi_bridge #(
  parameter int RATIO = `PSBI_CLK_RATIO
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_b_in,
  // Core side request
  input  wire logic                          req_valid_in,
  input  wire psbi_pkg::psbi_req_t           req_kind_in,
  input  wire logic [`PSBI_ADDR_W-1:0]       req_addr_in,
  input  wire logic [3:0]                    req_bytes_in,
  input  wire logic                          req_wt_in,
  input  wire logic                          req_ci_in,
  input  wire logic [`PSBI_DATA_W-1:0]       req_wdata_in,
  output logic                               req_ready_out,
  output logic                               wdata_next_out,
  output logic                               rdata_valid_out,
  output logic [`PSBI_DATA_W-1:0]            rdata_out,
  output logic                               done_out,
  output logic                               perr_out,
  // Bus pins (active low end in _b)
  output logic                               abr_b_out,
  input  wire logic                          abg_b_in,
  output logic                               dbr_b_out,
  input  wire logic                          dbg_b_in,
  output logic                               mem_start_b_out,
  output logic                               io_start_b_out,
  output logic [`PSBI_ADDR_W-1:0]            addr_out,
  output logic [3:0]                         addr_parity_bits_out,
  output logic                               addr_oe_out,
  output logic [4:0]                         transfer_type_code_out,
  output logic [2:0]                         tsiz_out,
  output logic                               burst_b_out,
  output logic                               wt_b_out,
  output logic                               ci_b_out,
  input  wire logic                          aack_b_in,
  input  wire logic                          address_retry_b_in,
  input  wire logic                          ape_b_in,
  input  wire logic [`PSBI_DATA_W-1:0]       data_in,
  input  wire logic [7:0]                    dpar_in,
  output logic [`PSBI_DATA_W-1:0]            data_out,
  output logic [7:0]                         dpar_out,
  output logic                               data_oe_out,
  input  wire logic                          ta_b_in,
  input  wire logic                          dretry_b_in,
  output logic                               dpe_b_out
);
  import psbi_pkg::*;
  initial begin
    if (`PSBI_BURST_BEATS * 8 != `PSBI_SECTOR_BYTES) $error("Burst must cover a sector");
  end

  // Byte parity of a data word, also used for the address [RL17] [RL18]
  function automatic logic [7:0] par8(input logic [63:0] v);
    logic [7:0] p;
    p = '0;
    for (int i = 0; i < 8; i++) p[i] = ^v[8*i +: 8];
    return p;
  endfunction : par8

  // Synchronised pin inputs; active-low inputs reset to negated [RL20]
  logic abg_s, dbg_s, aack_s, address_retry_s, ape_s, ta_s, dretry_s;
  logic [`PSBI_DATA_W-1:0] din_s;
  logic [7:0]              dpin_s;
  wire logic [7:0] dpin_in_w = dpar_in;  // Parity lane bundle
  psbi_sync #(.W(7), .RSTV(7'h7F)) u_sync_ctl (
    .mclk_in (mclk_in),
    .rst_b_in(rst_b_in),
    .d_in    ({abg_b_in, dbg_b_in, aack_b_in, address_retry_b_in, ape_b_in, ta_b_in,
                dretry_b_in}),
    .q_out   ({abg_s, dbg_s, aack_s, address_retry_s, ape_s, ta_s, dretry_s})
  );
  psbi_sync #(.W(72), .RSTV(72'h0)) u_sync_dat (
    .mclk_in (mclk_in),
    .rst_b_in(rst_b_in),
    .d_in    ({dpin_in_w, data_in}),
    .q_out   ({dpin_s, din_s})
  );

  // Bus clock enable; grant, acknowledge and beat decisions happen on it [RL5]
  logic bus_en;
  psbi_bus_clk #(.RATIO(RATIO)) u_bclk (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .bus_en_out(bus_en)
  );

  // Latched request
  psbi_req_t               kind_q;
  logic [`PSBI_ADDR_W-1:0] addr_q;
  logic [3:0]              bytes_q;
  logic                    wt_q, ci_q;
  psbi_ast_t               ast_q;
  psbi_dst_t               dst_q;
  logic                    dpend_q;   // Data tenure owed by taken address
  logic [1:0]              beat_q;    // Burst beat counter
  logic                    rd_q;      // Pending data tenure is a read

  // Decode of request kind
  wire logic is_burst  = (kind_q == PSBI_REQ_FILL) || (kind_q == PSBI_REQ_WBACK);  // [RL9]
  wire logic addr_only = (kind_q == PSBI_REQ_INVAL);                              // [RL10]
  wire logic is_io     = (kind_q == PSBI_REQ_IO);                                 // [RL11]
  wire logic is_read   = (kind_q == PSBI_REQ_READ) || (kind_q == PSBI_REQ_FILL);
  // Type code from request kind; ci and wt do not force single beats [RL8] [RL7]
  wire logic [4:0] tt_w = addr_only ? `PSBI_TT_KILL :
                          is_io     ? `PSBI_TT_IO   :
                          is_read   ? `PSBI_TT_READ : `PSBI_TT_WRITE;
  wire logic [2:0] tsiz_w = is_burst ? 3'h2 : bytes_q[2:0];  // 8 bytes encodes 0 [RL6]
  wire logic [7:0] apar_w = par8({32'h0, addr_q});

  // Address accepted, retried or not yet
  wire logic a_ack   = bus_en && (ast_q == PSBI_A_WAIT) && !aack_s;         // [RL14]
  wire logic a_retry = a_ack && !address_retry_s;                                    // [RL14]
  wire logic a_done  = a_ack && address_retry_s;
  // Data beat terminations
  wire logic d_term  = bus_en && (dst_q == PSBI_D_BEAT) && !ta_s;            // [RL15]
  wire logic d_retry = bus_en && (dst_q == PSBI_D_BEAT) && !dretry_s;        // [RL16]
  logic      rd_burst_q;  // Current data tenure is a burst
  wire logic d_last  = d_term && (!rd_burst_q || beat_q == 2'h3);

  // Address tenure machine; separate from data, but no new address while data is owed [RL3] [RL4]
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ast_q   <= PSBI_A_IDLE;
      kind_q  <= PSBI_REQ_READ;
      addr_q  <= '0;
      bytes_q <= '0;
      wt_q    <= 1'b0;
      ci_q    <= 1'b0;
    end else begin
      unique case (ast_q)
        PSBI_A_IDLE: if (req_valid_in && !dpend_q) begin
          ast_q   <= PSBI_A_REQ;
          kind_q  <= req_kind_in;
          addr_q  <= req_addr_in;
          bytes_q <= req_bytes_in;
          wt_q    <= req_wt_in;
          ci_q    <= req_ci_in;
        end
        PSBI_A_REQ: if (bus_en && !abg_s) ast_q <= PSBI_A_DRV;  // Grant first [RL23] [RL21]
        PSBI_A_DRV: if (bus_en) ast_q <= PSBI_A_WAIT;            // Start is one bus cycle
        PSBI_A_WAIT: begin
          if (a_retry) ast_q <= PSBI_A_REQ;                      // Repeat address [RL14]
          else if (a_done) ast_q <= PSBI_A_IDLE;                 // Release bus [RL23]
        end
      endcase
    end
  end

  // Data tenure machine with its own grant [RL21]
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      dst_q      <= PSBI_D_IDLE;
      dpend_q    <= 1'b0;
      beat_q     <= '0;
      rd_q       <= 1'b0;
      rd_burst_q <= 1'b0;
    end else begin
      if (a_done && !addr_only) begin  // Address-only owes no data [RL2]
        dpend_q    <= 1'b1;
        rd_q       <= is_read;
        rd_burst_q <= is_burst;
      end
      unique case (dst_q)
        PSBI_D_IDLE: if (dpend_q || (a_done && !addr_only)) dst_q <= PSBI_D_REQ;
        PSBI_D_REQ: if (bus_en && !dbg_s) begin                   // [RL23]
          dst_q  <= PSBI_D_BEAT;
          beat_q <= '0;
        end
        PSBI_D_BEAT: begin
          if (d_retry) beat_q <= beat_q;                         // Same beat again [RL16]
          else if (d_last) begin
            dst_q   <= PSBI_D_IDLE;                              // End tenure [RL15]
            dpend_q <= 1'b0;
          end else if (d_term) beat_q <= beat_q + 2'h1;          // Four beats [RL7]
        end
        default: dst_q <= PSBI_D_IDLE;
      endcase
    end
  end

  // Pin and core outputs, all registered; floated in reset [RL22] [RL20]
  wire logic drv_a = (ast_q == PSBI_A_DRV) || (ast_q == PSBI_A_WAIT);
  wire logic drv_d = (dst_q == PSBI_D_BEAT) && !rd_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      abr_b_out <= 1'b1; dbr_b_out <= 1'b1;
      mem_start_b_out <= 1'b1; io_start_b_out <= 1'b1;
      addr_out <= '0; addr_parity_bits_out <= '0; addr_oe_out <= 1'b0;
      transfer_type_code_out <= '0; tsiz_out <= '0;
      burst_b_out <= 1'b1; wt_b_out <= 1'b1; ci_b_out <= 1'b1;
      data_out <= '0; dpar_out <= '0; data_oe_out <= 1'b0; dpe_b_out <= 1'b1;
      req_ready_out <= 1'b0; wdata_next_out <= 1'b0; rdata_valid_out <= 1'b0;
      rdata_out <= '0; done_out <= 1'b0; perr_out <= 1'b0;
    end else begin
      abr_b_out <= !(ast_q == PSBI_A_REQ);                                // [RL21]
      dbr_b_out <= !(dst_q == PSBI_D_REQ);
      mem_start_b_out <= !((ast_q == PSBI_A_DRV) && !is_io);              // [RL12]
      io_start_b_out  <= !((ast_q == PSBI_A_DRV) && is_io);               // [RL12] [RL13]
      addr_oe_out <= drv_a;                                               // [RL23]
      addr_out <= addr_q;                                                 // [RL1]
      addr_parity_bits_out <= apar_w[3:0];  // One bit per address byte [RL17]
      transfer_type_code_out <= tt_w;                                     // [RL19]
      tsiz_out    <= tsiz_w;
      burst_b_out <= !is_burst;
      wt_b_out    <= !wt_q;
      ci_b_out    <= !ci_q;
      data_oe_out <= drv_d;
      data_out    <= req_wdata_in;                                        // [RL1]
      dpar_out    <= par8(req_wdata_in);                                  // [RL18]
      dpe_b_out   <= !(d_term && rd_q && (par8(din_s) != dpin_s));        // [RL18]
      req_ready_out   <= (ast_q == PSBI_A_IDLE) && !dpend_q;
      wdata_next_out  <= d_term && !rd_q && !d_retry;
      rdata_valid_out <= d_term && rd_q && !d_retry;
      rdata_out       <= din_s;
      done_out <= (a_done && addr_only) || (d_last && !d_retry);
      perr_out <= !ape_s || (d_term && rd_q && (par8(din_s) != dpin_s));
    end
  end

  // Address pins only driven with grant-started tenure
  addr_grant_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(addr_oe_out) |-> $past(abg_s, 2) == 1'b0 || $past(abg_s, 3) == 1'b0) // [RL23]
    else $error("Address driven without grant");
  start_excl_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(mem_start_b_out == 1'b0 && io_start_b_out == 1'b0)) // [RL12]
    else $error("Both transfer starts asserted");
  burst_len_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (d_term && rd_burst_q && beat_q != 2'h3 && !d_retry) |=> (dst_q == PSBI_D_BEAT)) // [RL7]
    else $error("Burst ended before fourth beat");
  retry_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    d_retry |=> $stable(beat_q) && dst_q == PSBI_D_BEAT) // [RL16]
    else $error("Data retry did not repeat beat");
  aretry_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    a_retry |=> ast_q == PSBI_A_REQ) // [RL14]
    else $error("Address retry not repeated");
  inval_nodata_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (a_done && addr_only && !dpend_q) |=> !dpend_q) // [RL10]
    else $error("Address-only tenure owed data");
  reset_float_a: assert property (@(posedge mclk_in)
    !rst_b_in |=> !addr_oe_out && !data_oe_out) // [RL22]
    else $error("Pins driven after reset");
  single_beat_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (d_term && !rd_burst_q && !d_retry) |=> dst_q == PSBI_D_IDLE) // [RL15]
    else $error("Single beat tenure not ended");
  cov_burst_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) d_last && rd_burst_q);
  cov_aretry_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) a_retry);
  cov_overlap_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    drv_a && dst_q == PSBI_D_BEAT);
endmodule : psbi_bridge

// *** hdl/psbi_params.svh ***
// Constants for the processor system bus interface: widths, codes and counts
`ifndef PSBI_PARAMS_SVH
`define PSBI_PARAMS_SVH
`define PSBI_ADDR_W        32
`define PSBI_DATA_W        64
`define PSBI_BURST_BEATS   4
`define PSBI_SECTOR_BYTES  32
`define PSBI_IO_MAX_BYTES  128
`define PSBI_CLK_RATIO     2
`define PSBI_TT_READ       5'h0A
`define PSBI_TT_WRITE      5'h02
`define PSBI_TT_FLUSH      5'h04
`define PSBI_TT_KILL       5'h0C
`define PSBI_TT_IO         5'h10
`endif

// *** hdl/psbi_pkg.sv ***
// Types shared by the processor system bus interface files
package psbi_pkg;
  // Request kinds from the core and cache
  typedef enum logic [2:0] {
    PSBI_REQ_READ  = 3'h0,
    PSBI_REQ_WRITE = 3'h1,
    PSBI_REQ_FILL  = 3'h2,
    PSBI_REQ_WBACK = 3'h3,
    PSBI_REQ_INVAL = 3'h4,
    PSBI_REQ_IO    = 3'h5
  } psbi_req_t;
  // Address tenure states
  typedef enum logic [1:0] {
    PSBI_A_IDLE = 2'h0,
    PSBI_A_REQ  = 2'h1,
    PSBI_A_DRV  = 2'h2,
    PSBI_A_WAIT = 2'h3
  } psbi_ast_t;
  // Data tenure states
  typedef enum logic [1:0] {
    PSBI_D_IDLE = 2'h0,
    PSBI_D_REQ  = 2'h1,
    PSBI_D_BEAT = 2'h2
  } psbi_dst_t;
endpackage : psbi_pkg

// *** hdl/psbi_sync.sv ***
// Two-flop synchroniser for inputs arriving from bus pins
`timescale 1ns/1ns
module psbi_sync #(
  parameter int W     = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;  // First stage, read only by second
  // Two stages; both load RSTV in reset
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      meta_q <= RSTV;
      q_out  <= RSTV;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : psbi_sync

// *** hdl/psbi_bus_clk.sv ***
// Bus clock enable divider: one-cycle pulse every RATIO processor cycles
`include "psbi_params.svh"
`timescale 1ns/1ns
module psbi_bus_clk #(
  parameter int RATIO = `PSBI_CLK_RATIO
) (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  output logic      bus_en_out
);
  localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
  logic [CW-1:0] cnt_q;  // Processor cycles into bus cycle
  initial begin
    if (RATIO < 1) $error("RATIO must be at least 1");
  end
  // Integer ratio keeps bus edges on processor edges [RL5]
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_q      <= '0;
      bus_en_out <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == CW'(RATIO - 1)) ? '0 : cnt_q + CW'(1);
      bus_en_out <= (cnt_q == CW'(RATIO - 1));
    end
  end
endmodule : psbi_bus_clk

// *** test/psbi_sys_model.sv ***
// System side model: arbiter plus address and data responder
`timescale 1ns/1ns
module psbi_sys_model (
  input  wire logic   mclk_in,
  input  wire logic   slow_in,                // Long grant and ack latency
  input  wire logic   arty_in,                // Retry first address tenure
  input  wire logic   drty_in,                // Retry first data beat
  input  wire logic   abr_b_in,
  input  wire logic   dbr_b_in,
  input  wire logic   addr_oe_in,
  input  wire logic   data_oe_in,
  input  wire logic   tend_in,                // Transaction end seen on core side
  output logic        abg_b_out = 1'b1,
  output logic        dbg_b_out = 1'b1,
  output logic        aack_b_out = 1'b1,
  output logic        address_retry_b_out = 1'b1,
  output logic        ta_b_out = 1'b1,
  output logic        dretry_b_out = 1'b1,
  output logic [63:0] data_out = 64'h0,
  output logic [7:0]  dpar_out = 8'h0
);
  int          ac = 0, ao = 0, dc = 0, tc = 0;  // Cycle counters per tenure
  int          na = 0, nd = 0;                  // Tenures seen while retrying
  int          lat, i;
  logic        pa = 0, pd = 0;                  // Previous tenure activity
  logic        db = 0;                          // Data bus granted, tenure running
  logic        a_on, d_on, rw;
  logic [63:0] dn;
  // Everything changes at the falling edge, away from the sampling edge
  always @(negedge mclk_in) begin
    lat = slow_in ? 6 : 0;
    a_on = !abr_b_in || addr_oe_in;
    d_on = !dbr_b_in || data_oe_in || db;
    ac = a_on ? ac + 1 : 0;
    ao = addr_oe_in ? ao + 1 : 0;
    dc = d_on ? dc + 1 : 0;
    tc = (d_on && !dbg_b_out) ? tc + 1 : 0;
    // Read tenures drop their request; keep the grant until the end
    db = !tend_in && (db || (d_on && !dbg_b_out));
    // Retry only the first tenure after the mode is set
    if (!arty_in) na = 0;
    else if (pa && !addr_oe_in) na++;
    if (!drty_in) nd = 0;
    else if (pd && !d_on) nd++;
    pa = addr_oe_in;
    pd = d_on;
    rw = drty_in && nd == 0 && tc > lat && tc <= lat + 4;
    abg_b_out <= !(a_on && ac > lat);
    dbg_b_out <= !(d_on && dc > lat);
    aack_b_out <= !(ao > lat + 1);
    address_retry_b_out <= !(ao > lat + 1 && arty_in && na == 0);
    dretry_b_out <= !rw;
    ta_b_out <= !(tc > lat && !rw);
    // Released bus shows a changing pattern, never the last value
    dn = tc > 0 ? 64'h5A5A_0F0F_C3C3_9696 : ~data_out;
    data_out <= dn;
    for (i = 0; i < 8; i++) dpar_out[i] <= ^dn[i*8+:8];
  end
endmodule : psbi_sys_model

// *** test/tb_processor_system_bus_interface.sv ***
// Self-checking bench for the processor system bus interface
`include "psbi_params.svh"
`timescale 1ns/1ns
module tb_processor_system_bus_interface;
  import psbi_pkg::*;
  logic        mclk_in = 0, rst_b_in = 0;
  logic        req_valid_in = 0, req_wt_in = 0, req_ci_in = 0;
  psbi_req_t   req_kind_in = PSBI_REQ_READ;
  logic [31:0] req_addr_in = 32'h0001_2340, addr_out;
  logic [3:0]  req_bytes_in = 4'h8, addr_parity_bits_out;
  logic [63:0] req_wdata_in = 64'hC0DE_0000_1111_0001, rdata_out, data_in, data_out;
  logic        slow = 0, arty = 0, drty = 0;  // Partner behaviour selects
  logic        ape_b_in = 1;                  // Address parity error pin
  logic        req_ready_out, wdata_next_out, rdata_valid_out, done_out, perr_out;
  logic        abr_b_out, abg_b_in, dbr_b_out, dbg_b_in, mem_start_b_out, io_start_b_out;
  logic        addr_oe_out, burst_b_out, wt_b_out, ci_b_out, aack_b_in, address_retry_b_in;
  logic        data_oe_out, ta_b_in, dretry_b_in, dpe_b_out;
  logic [4:0]  transfer_type_code_out;
  logic [2:0]  tsiz_out;
  logic [7:0]  dpar_in, dpar_out;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  psbi_bridge #(.RATIO(2)) dut (.mclk_in, .rst_b_in, .req_valid_in, .req_kind_in,
    .req_addr_in, .req_bytes_in, .req_wt_in, .req_ci_in, .req_wdata_in, .req_ready_out,
    .wdata_next_out, .rdata_valid_out, .rdata_out, .done_out, .perr_out, .abr_b_out,
    .abg_b_in, .dbr_b_out, .dbg_b_in, .mem_start_b_out, .io_start_b_out, .addr_out,
    .addr_parity_bits_out, .addr_oe_out, .transfer_type_code_out, .tsiz_out, .burst_b_out,
    .wt_b_out, .ci_b_out, .aack_b_in, .address_retry_b_in, .ape_b_in, .data_in,
    .dpar_in, .data_out, .dpar_out, .data_oe_out, .ta_b_in, .dretry_b_in, .dpe_b_out);
  psbi_sys_model sys (.mclk_in, .slow_in(slow), .arty_in(arty), .drty_in(drty),
    .abr_b_in(abr_b_out), .dbr_b_in(dbr_b_out), .addr_oe_in(addr_oe_out),
    .data_oe_in(data_oe_out), .tend_in(done_out), .abg_b_out(abg_b_in), .dbg_b_out(dbg_b_in),
    .aack_b_out(aack_b_in), .address_retry_b_out(address_retry_b_in), .ta_b_out(ta_b_in),
    .dretry_b_out(dretry_b_in), .data_out(data_in), .dpar_out(dpar_in));
  // 50 MHz clock
  always #10 mclk_in = ~mclk_in;
  // Hang guard: far above the longest expected run
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  // Single value comparison with report
  task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // One whole transaction; negative expected counts skip that check
  task automatic xfer(input psbi_req_t k, input logic [3:0] b, input logic wt, ci,
                      input int nrd, nwr, ns, input logic bst, io);
    int         rd, wr, st, ist, i;
    logic       pm, pi, fin, bb, wb, cb;
    logic [4:0] tt;
    logic [2:0] tz;
    logic [7:0] ep;
    logic [3:0] ap;
    rd = 0; wr = 0; st = 0; ist = 0; pm = 1; pi = 1; fin = 0; bb = 1; wb = 1; cb = 1;
    for (i = 0; i < 8; i++) ep[i] = ^req_wdata_in[8*i +: 8];
    for (i = 0; i < 4; i++) ap[i] = ^req_addr_in[8*i +: 8];
    tt = 5'h00; tz = 3'h0;
    for (i = 0; i < 200 && req_ready_out !== 1'b1; i++) @(posedge mclk_in);
    @(negedge mclk_in);
    req_kind_in = k; req_bytes_in = b; req_wt_in = wt; req_ci_in = ci;
    req_valid_in = 1;
    for (i = 0; i < 900 && !fin; i++) begin
      @(posedge mclk_in);
      #1;
      if (!mem_start_b_out && pm) begin
        st++; tt = transfer_type_code_out; tz = tsiz_out;
        bb = burst_b_out; wb = wt_b_out; cb = ci_b_out;
        chk("addr", req_addr_in, addr_out);
        chk("addr_par", ap, addr_parity_bits_out);
      end
      if (data_oe_out) chk("wdata", req_wdata_in, data_out);
      if (data_oe_out) chk("wdata_par", ep, dpar_out);
      if (perr_out !== 1'b0 || dpe_b_out !== 1'b1) chk("parity_flags", 0, 1);
      if (!io_start_b_out && pi) ist++;
      if (addr_oe_out && abg_b_in) chk("addr_drive_grant", 0, 1);
      if (data_oe_out && dbg_b_in) chk("data_drive_grant", 0, 1);
      if (rdata_valid_out) begin
        rd++;
        chk("rdata", 64'h5A5A_0F0F_C3C3_9696, rdata_out);
      end
      if (wdata_next_out) wr++;
      pm = mem_start_b_out; pi = io_start_b_out; fin = (done_out === 1'b1);
      @(negedge mclk_in);
      if (!req_ready_out) req_valid_in = 0;
    end
    req_valid_in = 0;
    chk("done", 1, fin);
    if (nrd >= 0) chk("read_beats", nrd, rd);
    if (nwr >= 0) chk("write_beats", nwr, wr);
    chk("mem_starts", io ? 0 : ns, st);
    chk("io_starts", io ? ns : 0, ist);
    if (!io) chk("burst_b", bst, bb);
    if (!io) chk("ci_b", !ci, cb);
    if (!io) chk("wt_b", !wt, wb);
    if (!io && bst) chk("tsiz", b == 8 ? 0 : b, tz);
    if (k == PSBI_REQ_READ) chk("tt_read", `PSBI_TT_READ, tt);
    if (k == PSBI_REQ_WRITE) chk("tt_write", `PSBI_TT_WRITE, tt);
  endtask : xfer
  // Pins float and negate while reset is held
  task automatic t_reset();
    repeat (20) @(negedge mclk_in);
    chk("reset_pins", 7'b0011111, {addr_oe_out, data_oe_out, abr_b_out, dbr_b_out,
        mem_start_b_out, io_start_b_out, dpe_b_out});
    rst_b_in = 1;
    @(negedge mclk_in);
    chk("ready_after_reset", 1, req_ready_out);
  endtask : t_reset
  // Inhibited single reads of every byte count
  task automatic t_sizes();
    for (int n = 1; n <= 8; n++) xfer(PSBI_REQ_READ, n, 0, 1, 1, 0, 1, 1, 0);
  endtask : t_sizes
  // Write-through store is one beat
  task automatic t_write();
    xfer(PSBI_REQ_WRITE, 8, 1, 0, 0, 1, 1, 1, 0);
  endtask : t_write
  // Sector fill and writeback are four-beat bursts
  task automatic t_burst();
    xfer(PSBI_REQ_FILL, 8, 0, 0, 4, 0, 1, 0, 0);
    xfer(PSBI_REQ_WBACK, 8, 0, 0, 0, 4, 1, 0, 0);
  endtask : t_burst
  // Invalidate has no data tenure
  task automatic t_inval();
    xfer(PSBI_REQ_INVAL, 8, 0, 0, 0, 0, 1, 1, 0);
  endtask : t_inval
  // I/O access uses its own start signal
  task automatic t_io();
    xfer(PSBI_REQ_IO, 8, 0, 0, -1, -1, 1, 1, 1);
  endtask : t_io
  // Address retry forces a second start
  task automatic t_aretry();
    arty = 1;
    xfer(PSBI_REQ_READ, 4, 0, 1, 1, 0, 2, 1, 0);
    arty = 0;
  endtask : t_aretry
  // Data retry repeats a beat without losing one
  task automatic t_dretry();
    drty = 1;
    xfer(PSBI_REQ_FILL, 8, 0, 0, 4, 0, 1, 0, 0);
    drty = 0;
  endtask : t_dretry
  // Slow arbiter: nothing driven before the grants arrive
  task automatic t_slow();
    slow = 1;
    xfer(PSBI_REQ_WBACK, 8, 0, 0, 0, 4, 1, 0, 0);
    xfer(PSBI_REQ_READ, 2, 0, 1, 1, 0, 1, 1, 0);
    slow = 0;
  endtask : t_slow
  // Address parity error pin reaches the core-side flag
  task automatic t_aperr();
    @(negedge mclk_in);
    ape_b_in = 0;
    repeat (4) @(negedge mclk_in);
    chk("perr_set", 1, perr_out);
    ape_b_in = 1;
    repeat (4) @(negedge mclk_in);
    chk("perr_clear", 0, perr_out);
  endtask : t_aperr
  // Count summary and final verdict
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    t_reset();
    t_sizes();
    t_write();
    t_burst();
    t_inval();
    t_io();
    t_aretry();
    t_dretry();
    t_slow();
    t_aperr();
    print_verdict();
  end
endmodule : tb_processor_system_bus_interface
